/* File: ext_irq_pkg.sv */
`default_nettype none
package ext_irq_pkg;
  // ***********************************************
  // register addresses
  // ***********************************************
  localparam logic [7:0] ADDR_MCU_CTRL = 8'h35;
  localparam logic [7:0] ADDR_FLAG = 8'h3c;
  localparam logic [7:0] ADDR_MASK = 8'h3d;
  localparam logic [7:0] ADDR_SENSE = 8'h69;
  localparam logic [7:0] ADDR_PAGE_BASE = 8'h75;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h76;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h77;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h78;

  // ***********************************************
  // field layout
  // ***********************************************
  localparam int NUM_PINS = 2;
  localparam int BIT_UNLOCK = 0;
  localparam int BIT_RELOC = 1;
  localparam int SENSE_W = 2;
  localparam int SENSE_A_LSB = 0;
  localparam int SENSE_B_LSB = 2;
  localparam int IRQ_W = 5;
  localparam int EV_EDGE_A = 0;
  localparam int EV_EDGE_B = 1;
  localparam int EV_LOW_A = 2;
  localparam int EV_LOW_B = 3;
  localparam int EV_REJECT = 4;

  // ***********************************************
  // sense encodings
  // ***********************************************
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // ***********************************************
  // vectors and timing
  // ***********************************************
  localparam int VEC_W = 16;
  localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
  localparam logic [7:0] PAGE_LOW_BITS = 8'h00;
  localparam logic [2:0] UNLOCK_WINDOW = 3'h6;
  localparam logic [2:0] WINDOW_LAST = 3'h1;
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic {LOCKED, UNLOCKED} lock_state_t;
endpackage : ext_irq_pkg
`default_nettype wire

/* File: ext_irq_and_vector_relocation.sv */
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ext_irq_and_vector_relocation
  import ext_irq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ext_irq_pin_a,
  input wire logic i_ext_irq_pin_b,
  input wire logic i_global_ie,
  input wire logic i_irq_ack_a,
  input wire logic i_irq_ack_b,
  output logic o_req_a,
  output logic o_req_b,
  output logic o_wake,
  input wire logic [VEC_W-1:0] i_vec_addr,
  output logic [VEC_W-1:0] o_vec_addr,
  output logic o_irq
);

  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    logic [NUM_PINS-1:0] s1;
    logic [NUM_PINS-1:0] s2;
    logic [NUM_PINS-1:0] s3;
    logic [NUM_PINS-1:0] lvl;
    logic [NUM_PINS-1:0] primed;
    logic [NUM_PINS-1:0] flag;
    logic [NUM_PINS-1:0] mask;
    logic [2*SENSE_W-1:0] sense;
    logic reloc;
    lock_state_t lock;
    logic [2:0] win_cnt;
    logic [7:0] page_base;
    logic [IRQ_W-1:0] ists;
    logic [IRQ_W-1:0] ien;
    logic [7:0] rdata;
    logic [NUM_PINS-1:0] req;
    logic wake;
    logic [VEC_W-1:0] vec;
    logic irq;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] acks;

  // pads are read whatever the pin direction
  assign pins = {i_ext_irq_pin_b, i_ext_irq_pin_a};
  assign acks = {i_irq_ack_b, i_irq_ack_a};

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    logic [NUM_PINS-1:0] rise;
    logic [NUM_PINS-1:0] fall;
    logic [NUM_PINS-1:0] hit;
    logic [NUM_PINS-1:0] low;
    logic [NUM_PINS-1:0] clr;
    logic [1:0] mode;
    logic [IRQ_W-1:0] ev;
    logic wr_ctrl;
    logic wr_flag;
    rise = '0;
    fall = '0;
    hit = '0;
    low = '0;
    clr = '0;
    mode = SENSE_LOW;
    ev = '0;
    st_d = st_q;
    wr_ctrl = i_wr && (i_addr == ADDR_MCU_CTRL);
    wr_flag = i_wr && (i_addr == ADDR_FLAG);

    // per pin: sync, filter, edge, flag, request
    for (int i = 0; i < NUM_PINS; i++) begin
      st_d.s1[i] = pins[i];
      st_d.s2[i] = st_q.s1[i];
      st_d.s3[i] = st_q.s2[i];
      // level accepted once second and third stages agree
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
        st_d.primed[i] = 1'b1;
      end
      // successive accepted samples give the edge
      rise[i] = st_q.primed[i] && !st_q.lvl[i] && st_d.lvl[i];
      fall[i] = st_q.primed[i] && st_q.lvl[i] && !st_d.lvl[i];
      mode = st_q.sense[i*SENSE_W +: SENSE_W];
      case (mode)
        SENSE_ANY: hit[i] = rise[i] || fall[i];
        SENSE_FALL: hit[i] = fall[i];
        SENSE_RISE: hit[i] = rise[i];
        default: hit[i] = 1'b0;
      endcase
      // low mode follows the pin level, no edge needed
      low[i] = (mode == SENSE_LOW) && st_q.primed[i] && !st_q.lvl[i];
      // service or a written one clears; a new edge wins
      clr[i] = acks[i] || (wr_flag && i_wdata[i]);
      st_d.flag[i] = hit[i] || (st_q.flag[i] && !clr[i]);
      if (mode == SENSE_LOW) begin
        st_d.req[i] = i_global_ie && st_q.mask[i] && low[i];
      end else begin
        st_d.req[i] = i_global_ie && st_q.mask[i] && st_q.flag[i];
      end
    end

    // wake request from an enabled low level
    st_d.wake = |(st_q.mask & low);

    // plain registers
    if (i_wr && (i_addr == ADDR_MASK)) begin
      st_d.mask = i_wdata[NUM_PINS-1:0];
    end
    if (i_wr && (i_addr == ADDR_SENSE)) begin
      st_d.sense = i_wdata[2*SENSE_W-1:0];
    end
    if (i_wr && (i_addr == ADDR_PAGE_BASE)) begin
      st_d.page_base = i_wdata;
    end
    if (i_wr && (i_addr == ADDR_IRQ_ENABLE)) begin
      st_d.ien = i_wdata[IRQ_W-1:0];
    end

    // guarded control register
    case (st_q.lock)
      LOCKED: begin
        if (wr_ctrl && i_wdata[BIT_UNLOCK]) begin
          st_d.lock = UNLOCKED;
          st_d.win_cnt = UNLOCK_WINDOW;
        end else if (wr_ctrl) begin
          ev[EV_REJECT] = 1'b1;
        end
      end
      UNLOCKED: begin
        if (wr_ctrl) begin
          st_d.reloc = i_wdata[BIT_RELOC];
          st_d.lock = LOCKED;
        end else if (st_q.win_cnt == WINDOW_LAST) begin
          st_d.lock = LOCKED;
        end else begin
          st_d.win_cnt = st_q.win_cnt - WINDOW_LAST;
        end
      end
      default: st_d.lock = LOCKED;
    endcase

    // vector address for the core
    if (i_vec_addr == RESET_VECTOR) begin
      st_d.vec = RESET_VECTOR;
    end else if (st_q.reloc) begin
      st_d.vec = {st_q.page_base, PAGE_LOW_BITS} + i_vec_addr;
    end else begin
      st_d.vec = i_vec_addr;
    end

    // sticky events, set wins over clear
    ev[EV_EDGE_A] = hit[0];
    ev[EV_EDGE_B] = hit[1];
    ev[EV_LOW_A] = low[0];
    ev[EV_LOW_B] = low[1];
    if (i_wr && (i_addr == ADDR_IRQ_CLEAR)) begin
      st_d.ists = ev | (st_q.ists & ~i_wdata[IRQ_W-1:0]);
    end else begin
      st_d.ists = ev | st_q.ists;
    end
    st_d.irq = |(st_q.ists & st_q.ien);

    // read data, valid in the cycle after the strobe only
    st_d.rdata = REG_RESET;
    if (i_rd) begin
      case (i_addr)
        ADDR_MCU_CTRL: begin
          st_d.rdata[BIT_UNLOCK] = (st_q.lock == UNLOCKED);
          st_d.rdata[BIT_RELOC] = st_q.reloc;
        end
        ADDR_FLAG: st_d.rdata[NUM_PINS-1:0] = st_q.flag;
        ADDR_MASK: st_d.rdata[NUM_PINS-1:0] = st_q.mask;
        ADDR_SENSE: st_d.rdata[2*SENSE_W-1:0] = st_q.sense;
        ADDR_PAGE_BASE: st_d.rdata = st_q.page_base;
        ADDR_IRQ_STATUS: st_d.rdata[IRQ_W-1:0] = st_q.ists;
        ADDR_IRQ_ENABLE: st_d.rdata[IRQ_W-1:0] = st_q.ien;
        default: st_d.rdata = REG_RESET;
      endcase
    end
  end

  // ***********************************************
  // registers
  // ***********************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_q <= '0;
      // sync chain starts at the idle high pad level, so no false edge follows reset
      st_q.s1 <= '1;
      st_q.s2 <= '1;
      st_q.s3 <= '1;
      st_q.lvl <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign o_rdata = st_q.rdata;
  assign o_req_a = st_q.req[0];
  assign o_req_b = st_q.req[1];
  assign o_wake = st_q.wake;
  assign o_vec_addr = st_q.vec;
  assign o_irq = st_q.irq;

endmodule : ext_irq_and_vector_relocation
`default_nettype wire

/* File: ext_irq_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_irq_checker
  import ext_irq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_ext_irq_pin_a,
  input wire logic i_ext_irq_pin_b,
  input wire logic i_global_ie,
  input wire logic i_irq_ack_a,
  input wire logic i_irq_ack_b,
  input wire logic o_req_a,
  input wire logic o_req_b,
  input wire logic o_wake,
  input wire logic [VEC_W-1:0] i_vec_addr,
  input wire logic [VEC_W-1:0] o_vec_addr,
  input wire logic o_irq
);
  // ***
  // port relations
  // ***
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_rst_vec; i_vec_addr == 16'h0000 |=> o_vec_addr == RESET_VECTOR; endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector moved");
  property p_vec; i_vec_addr != 16'h0000 |=> o_vec_addr[7:0] == $past(i_vec_addr[7:0]); endproperty
  a_vec: assert property (p_vec) else $error("vector low byte changed");
  property p_gie; !i_global_ie |=> !o_req_a && !o_req_b; endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");
  property p_rd_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_sense; i_rd && i_addr == ADDR_SENSE |=> o_rdata[7:4] == 4'h0; endproperty
  a_sense: assert property (p_sense) else $error("sense spare bits set");
  property p_flag; i_rd && i_addr == ADDR_FLAG |=> o_rdata[7:2] == 6'h00; endproperty
  a_flag: assert property (p_flag) else $error("flag spare bits set");
  property p_mask; i_rd && i_addr == ADDR_MASK |=> o_rdata[7:2] == 6'h00; endproperty
  a_mask: assert property (p_mask) else $error("mask spare bits set");
  property p_quiet; (i_ext_irq_pin_a && i_ext_irq_pin_b) [*8] |-> !o_wake; endproperty
  a_quiet: assert property (p_quiet) else $error("wake with pins high");
endmodule : ext_irq_checker
bind ext_irq_and_vector_relocation ext_irq_checker u_chk (.*);
`default_nettype wire

/* File: ext_pin_source.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_pin_source (
  input wire logic i_mclk,
  input wire logic [1:0] i_level,
  output logic o_pin_a,
  output logic o_pin_b
);
  logic [1:0] lvl_q = 2'b11;
  // pins follow the command a clock later and hold until released
  always @(posedge i_mclk) begin
    lvl_q <= i_level;
  end
  // pad levels
  assign o_pin_a = lvl_q[0];
  assign o_pin_b = lvl_q[1];
endmodule : ext_pin_source
`default_nettype wire

/* File: ext_irq_and_vector_relocation_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_irq_and_vector_relocation_test;
  import ext_irq_pkg::*;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_global_ie = 1'b0;
  logic i_irq_ack_a = 1'b0, i_irq_ack_b = 1'b0, o_req_a, o_req_b, o_wake, o_irq;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic [1:0] lvl = 2'b11;
  logic [15:0] i_vec_addr = 16'h0004, o_vec_addr;
  wire logic i_ext_irq_pin_a, i_ext_irq_pin_b;
  int n_fail = 0, compares = 0, cycles = 0;
  ext_irq_and_vector_relocation i_dut (.*);
  ext_pin_source u_src (.i_mclk(i_mclk), .i_level(lvl), .o_pin_a(i_ext_irq_pin_a), .o_pin_b(i_ext_irq_pin_b));
  // ***
  // helpers
  // ***
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    cyc(1);
    i_rd <= 1'b0;
    chk({8'h00, o_rdata}, {8'h00, e});
  endtask : rd
  task automatic pins(input logic [1:0] v);
    lvl <= v;
    cyc(7);
  endtask : pins
  task automatic close_out;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  // clock and hang guard
  initial forever #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      close_out();
    end
  end
  // main sequence
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(ADDR_MCU_CTRL, 8'h00);
    rd(ADDR_FLAG, 8'h00);
    rd(ADDR_PAGE_BASE, 8'h00);
    rd(8'h10, 8'h00);
    wr(ADDR_SENSE, 8'hff);
    rd(ADDR_SENSE, 8'h0f);
    for (int m = 1; m < 4; m++) begin
      wr(ADDR_SENSE, {4'h0, m[1:0], m[1:0]});
      pins(2'b00);
      rd(ADDR_FLAG, (m != 3) ? 8'h03 : 8'h00);
      wr(ADDR_FLAG, 8'h03);
      pins(2'b11);
      rd(ADDR_FLAG, (m != 2) ? 8'h03 : 8'h00);
      wr(ADDR_FLAG, 8'h03);
    end
    wr(ADDR_SENSE, 8'h00);
    wr(ADDR_MASK, 8'h01);
    i_global_ie <= 1'b1;
    pins(2'b00);
    chk(o_req_a, 1'b1);
    chk(o_req_b, 1'b0);
    rd(ADDR_FLAG, 8'h00);
    i_global_ie <= 1'b0;
    cyc(2);
    chk(o_wake, 1'b1);
    pins(2'b11);
    wr(ADDR_SENSE, 8'h0a);
    wr(ADDR_MASK, 8'h03);
    i_global_ie <= 1'b1;
    pins(2'b00);
    chk({o_req_a, o_req_b}, 2'b11);
    @(posedge i_mclk) i_irq_ack_a <= 1'b1;
    @(posedge i_mclk) i_irq_ack_a <= 1'b0;
    rd(ADDR_FLAG, 8'h02);
    wr(ADDR_FLAG, 8'h02);
    rd(ADDR_FLAG, 8'h00);
    pins(2'b11);
    wr(ADDR_IRQ_CLEAR, 8'h1f);
    wr(ADDR_IRQ_ENABLE, 8'h10);
    wr(ADDR_MCU_CTRL, 8'h01);
    cyc(5);
    wr(ADDR_MCU_CTRL, 8'h02);
    rd(ADDR_MCU_CTRL, 8'h00);
    chk(o_irq, 1'b1);
    wr(ADDR_IRQ_CLEAR, 8'h10);
    cyc(2);
    chk(o_irq, 1'b0);
    wr(ADDR_PAGE_BASE, 8'h12);
    wr(ADDR_MCU_CTRL, 8'h01);
    cyc(4);
    wr(ADDR_MCU_CTRL, 8'h02);
    rd(ADDR_MCU_CTRL, 8'h02);
    chk(o_vec_addr, 16'h1204);
    i_vec_addr <= 16'h0000;
    cyc(2);
    chk(o_vec_addr, 16'h0000);
    close_out();
  end
endmodule : ext_irq_and_vector_relocation_test
`default_nettype wire
